// ### hw/prot_annunciator.sv
// Protection supervision, inhibit masks, anomaly latch, horn and reporting
//
// How it works
// - Zero delay disables a protection
// - Over threshold goes active, trips after delay
// - Asserted inhibit level blocks masked protections
// - Unselected protections stay enabled always
// - Mask bit n selects protection n
// - New anomaly sounds horn and flashes code
// - Anomaly stays latched until acknowledged
// - Acknowledged warning clears when cause gone
// - Unacknowledged alarm blocks restart permission
// - Horn duration zero never sounds horn
// - Duration 999 holds horn until silence or acknowledge
// - Duration 1-998 ends horn on timeout
// - Silence stops horn only, keeps flashing
// - Reporting only when cloud enable set
// - Zero port server never contacted
// - Periodic reports, running and stopped intervals
// - Keep-alive report every configured minutes
// - Event reports gated by mask bits
// - Voltage type selects reported voltages
// - Heartbeat led flashes at all times, running or stopped
// - Acknowledged alarms clear on reset edge or off/reset key, cause absent
`timescale 1ns/1ps
`default_nettype none
`include "prot_defines.svh"
module prot_annunciator #(
   parameter int NPROT     = `NUM_PROT,
   parameter int NLVL      = `NUM_LEVELS,
   parameter int SEC_CYC   = `SEC_CYCLES,
   parameter int HB_CYC    = `HB_HALF_CYCLES,
   parameter int MIN_SECS  = 60
) (
   // Clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    arst_n_in,
   // Protection measurement and settings
   input  wire logic [NPROT-1:0]        over_thresh_in,
   input  wire logic [NPROT*16-1:0]     prot_delay_in,
   // Inhibit levels
   input  wire logic [NLVL-1:0]         inhibit_input_level_in,
   input  wire logic [NLVL*NPROT-1:0]   inhibit_mask_in,
   // Warning causes from plant
   input  wire logic                    warn_cause_in,
   // Panel
   input  wire logic                    ack_key_in,
   input  wire logic                    silence_key_in,
   input  wire logic                    off_reset_key_in,
   input  wire logic                    alarm_reset_input_in,
   input  wire logic [9:0]              horn_duration_in,
   // Reporting configuration
   input  wire logic                    cloud_enable_in,
   input  wire logic [15:0]             primary_port_in,
   input  wire logic [15:0]             secondary_port_in,
   input  wire logic [15:0]             run_interval_in,
   input  wire logic [15:0]             stop_interval_in,
   input  wire logic [15:0]             keepalive_min_in,
   input  wire logic [6:0]              event_mask_in,
   input  wire logic                    volt_type_in,
   input  wire logic                    gen_running_in,
   // Protection state
   output logic [NPROT-1:0]             prot_trip_out,
   output logic [NPROT-1:0]             prot_active_out,
   // Annunciation
   output logic                         alarm_latched_out,
   output logic                         warn_latched_out,
   output logic                         flash_out,
   output logic                         horn_out,
   output logic                         restart_ok_out,
   output logic                         heartbeat_out,
   // Reporting requests
   output logic                         report_periodic_out,
   output logic                         report_keepalive_out,
   output logic                         report_event_out,
   output logic                         use_primary_out,
   output logic                         use_secondary_out,
   output logic                         report_ll_volts_out
);
   // Refused at elaboration: the channel carrier and counters serve only these
   if (NPROT != `NUM_PROT || NLVL < 1 || SEC_CYC < 2 ||
       HB_CYC < 1 || MIN_SECS < 1) begin : g_bad_params
      $error("prot_annunciator: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Inhibit combine and protection channels
   logic [NPROT-1:0] inhibit_vec;
   logic [NPROT-1:0] trip_vec;
   logic [NPROT-1:0] act_vec;

   always_comb begin
      inhibit_vec = '0;
      for (int l = 0; l < NLVL; l++) begin
         // Mask bit n belongs to protection n, so a plain OR of levels serves
         if (inhibit_input_level_in[l]) inhibit_vec |= inhibit_mask_in[l*NPROT +: NPROT];
      end
   end

   // Tick for delay counting: one per second
   logic [31:0] sec_cnt_q, sec_cnt_d;
   logic        sec_tick;
   assign sec_tick = (sec_cnt_q == 32'(SEC_CYC - 1));

   always_comb begin
      sec_cnt_d = sec_tick ? '0 : sec_cnt_q + 32'h0000_0001;
   end

   genvar g;
   generate
      for (g = 0; g < NPROT; g++) begin : g_prot
         prot_if pif ();
         assign pif.over    = over_thresh_in[g];
         assign pif.inhibit = inhibit_vec[g];
         assign pif.delay   = prot_delay_in[g*16 +: 16];
         assign pif.tick    = sec_tick;
         assign trip_vec[g] = pif.trip;
         assign act_vec[g]  = pif.active;
         prot_channel u_chan (
            .clk_sys_in (clk_sys_in),
            .arst_n_in  (arst_n_in),
            .pif        (pif.chan)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////
   // Anomaly latches
   logic alarm_q, alarm_d;
   logic warn_q, warn_d;
   logic unack_q, unack_d;
   logic alarm_cause;
   logic new_anom;
   logic rst_in_q;
   logic alarm_clear;

   assign alarm_cause = |trip_vec;
   assign new_anom    = (alarm_cause && !alarm_q) || (warn_cause_in && !warn_q);
   // Edge from inactive to active on the reset input, or key in off/reset
   assign alarm_clear = (alarm_reset_input_in && !rst_in_q) || off_reset_key_in;

   always_comb begin
      alarm_d = alarm_q;
      warn_d  = warn_q;
      unack_d = unack_q;
      if (ack_key_in) unack_d = 1'b0;
      if (alarm_clear && !alarm_cause && !unack_q) alarm_d = 1'b0;
      if (!unack_q && !warn_cause_in) warn_d = 1'b0;
      // New anomaly wins over a clear in the same cycle
      if (alarm_cause) alarm_d = 1'b1;
      if (warn_cause_in) warn_d = 1'b1;
      if (new_anom) unack_d = 1'b1;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alarm_q  <= 1'b0;
         warn_q   <= 1'b0;
         unack_q  <= 1'b0;
         rst_in_q <= 1'b0;
      end else begin
         alarm_q  <= alarm_d;
         warn_q   <= warn_d;
         unack_q  <= unack_d;
         rst_in_q <= alarm_reset_input_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Horn timer
   logic        horn_q, horn_d;
   logic [9:0]  horn_sec_q, horn_sec_d;

   always_comb begin
      horn_d     = horn_q;
      horn_sec_d = horn_sec_q;
      // Seconds may wrap in latch mode, harmless as no timeout applies there
      if (horn_q && sec_tick) horn_sec_d = horn_sec_q + 10'h001;
      if (silence_key_in || ack_key_in) horn_d = 1'b0;
      if (horn_duration_in != `HORN_LATCH && horn_q && horn_sec_q >= horn_duration_in)
         horn_d = 1'b0;
      if (new_anom && horn_duration_in != `HORN_OFF) begin
         horn_d     = 1'b1;
         horn_sec_d = '0;
      end
      if (horn_duration_in == `HORN_OFF) horn_d = 1'b0;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         horn_q     <= 1'b0;
         horn_sec_q <= '0;
      end else begin
         horn_q     <= horn_d;
         horn_sec_q <= horn_sec_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Reporting counters
   logic [15:0] per_q, per_d;
   logic [15:0] ka_sec_q, ka_sec_d;
   logic [15:0] ka_min_q, ka_min_d;
   logic        per_fire, ka_fire, evt_fire;
   logic        port_ok;
   logic [15:0] ivl;

   assign ivl     = gen_running_in ? run_interval_in : stop_interval_in;
   // Both ports zero means nowhere to send, so hold every request back
   assign port_ok = (primary_port_in != '0) || (secondary_port_in != '0);

   // Minutes keep counting while keep-alive is zero, so a later non-zero
   // setting fires as soon as the running minute count reaches it, not after a full interval
   always_comb begin
      per_d    = per_q;
      ka_sec_d = ka_sec_q;
      ka_min_d = ka_min_q;
      per_fire = 1'b0;
      ka_fire  = 1'b0;
      if (!cloud_enable_in) begin
         per_d    = '0;
         ka_sec_d = '0;
         ka_min_d = '0;
      end else if (sec_tick) begin
         per_d = per_q + 16'h0001;
         if (ivl != '0 && per_d >= ivl) begin
            per_d    = '0;
            per_fire = 1'b1;
         end
         ka_sec_d = ka_sec_q + 16'h0001;
         if (ka_sec_d >= 16'(MIN_SECS)) begin
            ka_sec_d = '0;
            ka_min_d = ka_min_q + 16'h0001;
            if (keepalive_min_in != '0 && ka_min_d >= keepalive_min_in) begin
               ka_min_d = '0;
               ka_fire  = 1'b1;
            end
         end
      end
      evt_fire = ((alarm_cause && !alarm_q && event_mask_in[`EVT_ALARM_BIT]) ||
                  (warn_cause_in && !warn_q && event_mask_in[`EVT_WARN_BIT]));
   end

   logic per_r_q, ka_r_q, evt_r_q;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         per_q   <= '0;
         ka_sec_q <= '0;
         ka_min_q <= '0;
         per_r_q <= 1'b0;
         ka_r_q  <= 1'b0;
         evt_r_q <= 1'b0;
      end else begin
         per_q    <= per_d;
         ka_sec_q <= ka_sec_d;
         ka_min_q <= ka_min_d;
         per_r_q  <= per_fire && port_ok;
         ka_r_q   <= ka_fire && port_ok;
         evt_r_q  <= evt_fire && cloud_enable_in && port_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Heartbeat
   logic [31:0] hb_q, hb_d;
   logic        led_q, led_d;

   always_comb begin
      hb_d  = hb_q + 32'h0000_0001;
      led_d = led_q;
      if (hb_q == 32'(HB_CYC - 1)) begin
         hb_d  = '0;
         led_d = !led_q;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hb_q      <= '0;
         led_q     <= 1'b0;
         sec_cnt_q <= '0;
      end else begin
         hb_q      <= hb_d;
         led_q     <= led_d;
         sec_cnt_q <= sec_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prot_trip_out        = trip_vec;
   assign prot_active_out      = act_vec;
   assign alarm_latched_out    = alarm_q;
   assign warn_latched_out     = warn_q;
   assign flash_out            = unack_q;
   assign horn_out             = horn_q;
   assign restart_ok_out       = !(alarm_q && unack_q);
   assign heartbeat_out        = led_q;
   assign report_periodic_out  = per_r_q;
   assign report_keepalive_out = ka_r_q;
   assign report_event_out     = evt_r_q;
   assign use_primary_out      = cloud_enable_in && primary_port_in != '0;
   assign use_secondary_out    = cloud_enable_in && secondary_port_in != '0;
   assign report_ll_volts_out  = !volt_type_in;

   ////////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_inhibit_no_trip: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      ($past(inhibit_vec) & ~$past(trip_vec) & trip_vec) == '0) else $error("inhibited trip");
   a_latch_holds: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      alarm_q && unack_q |=> alarm_q) else $error("alarm dropped unacked");
   a_warn_autoclr: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      warn_q && !unack_q && !warn_cause_in |=> !warn_q) else $error("warn not cleared");
   a_restart_block: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      alarm_q && flash_out |-> !restart_ok_out) else $error("restart allowed");
   a_horn_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      horn_duration_in == `HORN_OFF |=> !horn_out) else $error("horn with zero");
   a_silence_keeps: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      silence_key_in && !ack_key_in && unack_q && !new_anom |=> !horn_out && flash_out)
      else $error("silence wrong");
   a_new_horn: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      new_anom && horn_duration_in != `HORN_OFF |=> horn_out && flash_out)
      else $error("no horn on anomaly");
   a_cloud_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      !cloud_enable_in |=> !report_event_out && !report_periodic_out)
      else $error("report while off");
   c_horn: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(horn_out));
   c_ack: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $fell(flash_out));
   c_per: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) report_periodic_out);
   c_warn_clr: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $fell(warn_q));
   a_alarm_clear: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      $fell(alarm_q) |-> $past(alarm_clear) && !$past(alarm_cause))
      else $error("alarm cleared without reset");
   a_no_port_report: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      primary_port_in == '0 && secondary_port_in == '0 |=>
      !report_periodic_out && !report_keepalive_out && !report_event_out) else $error("no port");
   a_horn_timeout: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      horn_q && horn_duration_in != `HORN_LATCH && horn_duration_in != `HORN_OFF &&
      horn_sec_q >= horn_duration_in && !new_anom |=> !horn_out) else $error("horn overran");
   a_ka_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      keepalive_min_in == '0 |=> !report_keepalive_out) else $error("keep-alive at zero");
endmodule : prot_annunciator
`default_nettype wire

// ### hw/prot_defines.svh
// Constants for the protection inhibit and annunciation block
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH
`define NUM_PROT         21
`define NUM_LEVELS       8
`define DELAY_W          16
`define HORN_W           10
`define HORN_OFF         10'h000
`define HORN_LATCH       10'h3e7
`define CLK_HZ           20000000
`define SEC_CYCLES       (`CLK_HZ)
`define RPT_W            16
`define RUN_IVL_DEF      16'h0384
`define STOP_IVL_DEF     16'h0e10
`define KA_IVL_DEF       16'h0000
`define SERVER_PORT_STD  16'hcf3c
`define EVT_ALARM_BIT    0
`define EVT_WARN_BIT     1
`define HB_HALF_CYCLES   (`CLK_HZ / 2)
`endif

// ### hw/prot_pkg.sv
// Types shared by the protection block
package prot_pkg;
   typedef enum logic [1:0] {ST_DISABLED, ST_ENABLED, ST_ACTIVE, ST_TRIP} prot_state_t;
endpackage : prot_pkg

// ### hw/prot_if.sv
// Per-protection carrier between top and channel
`timescale 1ns/1ps
`default_nettype none
interface prot_if;
   logic        over;
   logic        inhibit;
   logic [15:0] delay;
   logic        tick;
   logic        trip;
   logic        active;
   modport top (output over, inhibit, delay, tick, input trip, active);
   modport chan(input over, inhibit, delay, tick, output trip, active);
endinterface : prot_if
`default_nettype wire

// ### hw/prot_channel.sv
// One protection: enable, active, trip sequence
`timescale 1ns/1ps
`default_nettype none
`include "prot_defines.svh"
module prot_channel (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic arst_n_in,
   // Channel
   prot_if.chan      pif
);
   prot_pkg::prot_state_t     state_q, state_d;
   logic [`DELAY_W-1:0]       cnt_q, cnt_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         prot_pkg::ST_DISABLED: begin
            if (pif.delay != '0) state_d = prot_pkg::ST_ENABLED;
         end
         prot_pkg::ST_ENABLED: begin
            cnt_d = '0;
            if (pif.over) state_d = prot_pkg::ST_ACTIVE;
         end
         prot_pkg::ST_ACTIVE: begin
            if (!pif.over) state_d = prot_pkg::ST_ENABLED;
            else if (pif.tick) begin
               cnt_d = cnt_q + 1'b1;
               // Inhibit holds off the trip but leaves timing running
               if (cnt_d >= pif.delay && !pif.inhibit) state_d = prot_pkg::ST_TRIP;
            end
         end
         prot_pkg::ST_TRIP: begin
            if (!pif.over) state_d = prot_pkg::ST_ENABLED;
         end
         default: state_d = prot_pkg::ST_DISABLED;
      endcase
      if (pif.delay == '0) state_d = prot_pkg::ST_DISABLED;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= prot_pkg::ST_DISABLED;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign pif.trip   = (state_q == prot_pkg::ST_TRIP);
   assign pif.active = (state_q == prot_pkg::ST_ACTIVE);

   a_zero_delay_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      pif.delay == '0 |=> state_q == prot_pkg::ST_DISABLED) else $error("zero delay not off");
   a_trip_needs_over: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(pif.trip) |-> $past(pif.over) && !$past(pif.inhibit)) else $error("bad trip");
   a_drop_restores: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      pif.active && !pif.over && pif.delay != '0 |=> state_q == prot_pkg::ST_ENABLED)
      else $error("not restored");
   c_trip: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(pif.trip));
endmodule : prot_channel
`default_nettype wire

// ### sim/prot_panel_model.sv
// Panel keys and alarm reset input as seen from the far side
`timescale 1ns/1ps
`default_nettype none
module prot_panel_model (
   // Clock
   input  wire logic clk_sys_in,
   // Requests from the bench
   input  wire logic ack_req_in,
   input  wire logic sil_req_in,
   input  wire logic rst_req_in,
   // Keys and digital input
   output logic      ack_key_out,
   output logic      silence_key_out,
   output logic      alarm_reset_input_out
);
   initial begin
      ack_key_out           = 1'b0;
      silence_key_out       = 1'b0;
      alarm_reset_input_out = 1'b0;
   end
   // Falling edge only, so the block never sees a key change at its sampling edge
   always @(negedge clk_sys_in) begin
      ack_key_out           <= ack_req_in;
      silence_key_out       <= sil_req_in;
      alarm_reset_input_out <= rst_req_in;
   end
endmodule : prot_panel_model
`default_nettype wire

// ### sim/test_protection_inhibit_annunciator.sv
// Self-checking bench for the protection annunciator
`timescale 1ns/1ps
`default_nettype none
`include "prot_defines.svh"
module test_protection_inhibit_annunciator;
   localparam int TRIP = 0, ACT = 1, ALM = 2, WRN = 3, FLS = 4, HRN = 5, ROK = 6;
   localparam int HB = 7, RP = 8, RK = 9, RE = 10, UP = 11, US = 12, LV = 13, CNT = 14;
   typedef struct {int s; logic [31:0] e;} note_t;
   logic          clk_sys_in, arst_n_in, warn_c, off_key, cloud, volt, running;
   logic [20:0]   over, trip, act;
   logic [335:0]  dly;
   logic [7:0]    inh;
   logic [167:0]  mask;
   logic [9:0]    horn_dur;
   logic [15:0]   pport, sport, run_ivl, stop_ivl, ka_min;
   logic [6:0]    evm;
   logic          ack_rq, sil_rq, rst_rq, ack_k, sil_k, ars;
   logic          alarm, warn, flash, horn, rok, hb, rp, rk, re, up, us, llv;
   logic [31:0]   cnt;
   int            n_mismatch, comparisons, p, q, l;
   note_t         notes[$];
   event          chk_ev;
   wire logic [11:0] flags = {llv, us, up, re, rk, rp, hb, rok, horn, flash, warn, alarm};

   prot_annunciator #(.SEC_CYC(10), .HB_CYC(5), .MIN_SECS(2)) dut (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .over_thresh_in(over),
      .prot_delay_in(dly), .inhibit_input_level_in(inh), .inhibit_mask_in(mask),
      .warn_cause_in(warn_c), .ack_key_in(ack_k), .silence_key_in(sil_k),
      .off_reset_key_in(off_key), .alarm_reset_input_in(ars), .horn_duration_in(horn_dur),
      .cloud_enable_in(cloud), .primary_port_in(pport), .secondary_port_in(sport),
      .run_interval_in(run_ivl), .stop_interval_in(stop_ivl), .keepalive_min_in(ka_min),
      .event_mask_in(evm), .volt_type_in(volt), .gen_running_in(running),
      .prot_trip_out(trip), .prot_active_out(act), .alarm_latched_out(alarm),
      .warn_latched_out(warn), .flash_out(flash), .horn_out(horn), .restart_ok_out(rok),
      .heartbeat_out(hb), .report_periodic_out(rp), .report_keepalive_out(rk),
      .report_event_out(re), .use_primary_out(up), .use_secondary_out(us),
      .report_ll_volts_out(llv));

   prot_panel_model panel (
      .clk_sys_in(clk_sys_in), .ack_req_in(ack_rq), .sil_req_in(sil_rq),
      .rst_req_in(rst_rq), .ack_key_out(ack_k), .silence_key_out(sil_k),
      .alarm_reset_input_out(ars));

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   function automatic logic [31:0] obs(input int s);
      case (s)
         TRIP:    obs = {11'h000, trip};
         ACT:     obs = {11'h000, act};
         CNT:     obs = cnt;
         default: obs = {31'h0, flags[s-2]};
      endcase
   endfunction : obs

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic note(input int s, input logic [31:0] e);
      notes.push_back('{s, e});
      -> chk_ev;
   endtask : note

   // Monitor side of the scoreboard: oldest note first
   initial forever begin
      note_t n;
      @(chk_ev);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         check(obs(n.s), n.e);
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : cyc

   task automatic wait_hi(input int s, input int n);
      int i;
      i = 0;
      while (obs(s) == 0 && i < n) begin
         @(negedge clk_sys_in);
         i++;
      end
   endtask : wait_hi

   task automatic count(input int s, input int n);
      cnt = 0;
      repeat (n) begin
         @(negedge clk_sys_in);
         if (obs(s) === 32'h1) cnt++;
      end
   endtask : count

   // Requests go out with non-blocking writes so the model samples the old value
   task automatic press(input int k);
      @(negedge clk_sys_in);
      if (k == 0) ack_rq <= 1'b1;
      else if (k == 1) sil_rq <= 1'b1;
      else rst_rq <= 1'b1;
      @(negedge clk_sys_in);
      {ack_rq, sil_rq, rst_rq} <= 3'b000;
      cyc(3);
   endtask : press

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   // Whole run is about 1300 cycles; this limit only catches a hang
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_mismatch++;
      end_sim();
   end

   initial begin
      arst_n_in = 1'b0; over = '0; dly = {21{16'h0001}}; inh = 8'h00; mask = '0;
      warn_c = 1'b0; off_key = 1'b0; horn_dur = `HORN_OFF; cloud = 1'b0; pport = 16'h0000;
      sport = 16'h0000; run_ivl = `RUN_IVL_DEF; stop_ivl = `STOP_IVL_DEF;
      ka_min = `KA_IVL_DEF; evm = 7'h00; running = 1'b0; cnt = 0;
      {ack_rq, sil_rq, rst_rq} = 3'b000;
      void'($urandom(32'h34ac3de2));
      volt = 1'($urandom % 2);
      cyc(16);
      arst_n_in = 1'b1;
      note(ALM, 0);
      note(HRN, 0);
      note(ROK, 1);
      note(LV, {31'h0, ~volt});
      q = {31'h0, hb};
      cyc(5);
      note(HB, {31'h0, ~q[0]});
      $display("Test reset done");
      // A zero delay keeps the protection out of the sequence entirely
      dly[15:0] = 16'h0000;
      over[0] = 1'b1;
      cyc(60);
      note(ACT, 0);
      note(TRIP, 0);
      over[0] = 1'b0;
      dly[15:0] = 16'h0001;
      // Short excursion goes active but never trips
      dly[79:64] = 16'h0002;
      over[4] = 1'b1;
      cyc(3);
      note(ACT, 32'h10);
      over[4] = 1'b0;
      cyc(40);
      note(TRIP, 0);
      $display("Test enable and active done");
      cloud = 1'b1; pport = `SERVER_PORT_STD; evm = 7'h01;
      for (int i = 0; i < 3; i++) begin
         horn_dur = (i == 0) ? `HORN_OFF : (i == 1) ? `HORN_LATCH : 10'h003;
         p = i + 1;
         over[p] = 1'b1;
         wait_hi(TRIP, 40);
         note(TRIP, 32'h1 << p);
         wait_hi(RE, 4);
         note(RE, 1);
         cyc(2);
         note(HRN, {31'h0, i != 0});
         note(FLS, 1);
         note(ROK, 0);
         over[p] = 1'b0;
         cyc(40);
         note(ALM, 1);
         note(HRN, {31'h0, i == 1});
         press(1);
         note(HRN, 0);
         note(FLS, 1);
         press(0);
         note(FLS, 0);
         note(ROK, 1);
         note(ALM, 1);
         press(2);
         note(ALM, 0);
         $display("Test horn mode %0d done", i);
      end
      // Random level and protection, neighbour left unmasked
      l = $urandom % 8;
      p = $urandom % 21;
      q = (p + 1) % 21;
      mask[l*21+p] = 1'b1;
      inh[l] = 1'b1;
      over[p] = 1'b1;
      over[q] = 1'b1;
      cyc(40);
      note(TRIP, 32'h1 << q);
      inh[l] = 1'b0;
      cyc(12);
      note(TRIP, (32'h1 << q) | (32'h1 << p));
      over = '0;
      press(0);
      off_key = 1'b1;
      cyc(2);
      note(ALM, 0);
      off_key = 1'b0;
      $display("Test inhibit done");
      evm = 7'h02;
      warn_c = 1'b1;
      wait_hi(RE, 4);
      note(RE, 1);
      cyc(2);
      note(WRN, 1);
      press(0);
      note(WRN, 1);
      warn_c = 1'b0;
      cyc(3);
      note(WRN, 0);
      $display("Test warning done");
      run_ivl = 16'h0002; running = 1'b1;
      cyc(80);
      count(RP, 100);
      note(CNT, 5);
      note(UP, 1);
      running = 1'b0; stop_ivl = 16'h0003;
      cyc(80);
      count(RP, 120);
      note(CNT, 4);
      ka_min = 16'h0001;
      cyc(80);
      count(RK, 100);
      note(CNT, 5);
      pport = 16'h0000; sport = `SERVER_PORT_STD;
      cyc(2);
      note(UP, 0);
      note(US, 1);
      cyc(1);
      sport = 16'h0000;
      cyc(80);
      count(RP, 120);
      note(CNT, 0);
      sport = `SERVER_PORT_STD; cloud = 1'b0;
      cyc(2);
      note(US, 0);
      count(RK, 100);
      note(CNT, 0);
      $display("Test reporting done");
      #1;
      end_sim();
   end
endmodule : test_protection_inhibit_annunciator
`default_nettype wire
